// ==== hdl/ssnv_pkg.sv ====
// ssnv_pkg: constants, command layout and state types of the serial shadow nvram control.
// assumes a 125 MHz system clock and a host that bit-bangs the serial link.
package ssnv_pkg;

    // serial framing and memory shape
    localparam int INSTR_BITS = 8;
    localparam int WORD_BITS = 16;
    localparam int WORDS = 16;
    localparam int ADDR_BITS = 4;
    localparam int CNT_BITS = 4;

    // instruction layout: start bit, address field, operation field
    localparam int INSTR_START_POS = 7;
    localparam int ADDR_MSB = 6;
    localparam int ADDR_LSB = 3;
    localparam int OP_MSB = 2;

    // operation codes
    localparam logic [2:0] OP_WRITE = 3'h3;
    localparam logic [1:0] OP_READ = 2'h3;
    localparam logic [ADDR_BITS-1:0] CTL_ADDR = 4'hF;
    localparam logic [2:0] CTL_WRDIS = 3'h0;
    localparam logic [2:0] CTL_STORE = 3'h1;
    localparam logic [2:0] CTL_WREN = 3'h4;
    localparam logic [2:0] CTL_RECALL = 3'h5;

    // store timing
    localparam int STORE_TIME_MS = 10;
    localparam int CLK_FREQ_MHZ = 125;
    localparam int STORE_CYCLES = STORE_TIME_MS * 1000 * CLK_FREQ_MHZ;

    // crossing buffers
    localparam int FIFO_DEPTH = 2;

    // reset values
    localparam logic STORE_IN_IDLE = 1'b1;
    localparam logic WREN_RESET = 1'b0;

    typedef enum logic [2:0] {K_READ, K_WRITE, K_STORE, K_RECALL, K_WREN, K_WRDIS} ssnv_kind_t;

    typedef struct packed {
        ssnv_kind_t kind;
        logic [ADDR_BITS-1:0] addr;
        logic [WORD_BITS-1:0] data;
    } ssnv_cmd_t;

    typedef logic [WORDS-1:0][WORD_BITS-1:0] ssnv_mem_t;

    typedef enum logic [2:0] {L_INSTR, L_WDATA, L_RWAIT, L_RDATA, L_DONE} ssnv_lstate_t;

    typedef enum logic [1:0] {M_BOOT, M_IDLE, M_STORE} ssnv_mstate_t;

endpackage

// ==== hdl/ssnv_sync2.sv ====
// ssnv_sync2: two flip-flop synchroniser for a level or a gray-coded word.
// assumes the input changes at most one bit at a time when wider than one.
`timescale 1ns/1ps
module ssnv_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] hold_ff;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            meta_ff <= RESET_VAL;
            hold_ff <= RESET_VAL;
        end
        else
        begin
            meta_ff <= d;
            hold_ff <= meta_ff;
        end
    end

    assign q = hold_ff;
endmodule // ssnv_sync2

// ==== hdl/ssnv_afifo.sv ====
// ssnv_afifo: small dual-clock buffer with gray pointers, valid and ready on both sides.
// assumes DEPTH is a power of two; a stopped clock on one side makes it look fuller to that side's writer, emptier to its reader.
`timescale 1ns/1ps
module ssnv_afifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic wrClk,
    input wire logic wrRstN,
    input wire logic wrValid,
    output logic wrReady,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic rdClk,
    input wire logic rdRstN,
    output logic rdValid,
    input wire logic rdReady,
    output logic [WIDTH-1:0] rdData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_MASK = (AW + 1)'(3) << (AW - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrBin_ff;
    logic [AW:0] wrGray_ff;
    logic [AW:0] rdBin_ff;
    logic [AW:0] rdGray_ff;
    logic [AW:0] rdGraySync;
    logic [AW:0] wrGraySync;

    function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    // pointer arithmetic and flags
    wire wrDo = wrValid & wrReady;
    wire rdDo = rdValid & rdReady;
    wire [AW:0] nxt_wrBin = wrBin_ff + (AW + 1)'(1);
    wire [AW:0] nxt_rdBin = rdBin_ff + (AW + 1)'(1);
    assign wrReady = (wrGray_ff != (rdGraySync ^ FULL_MASK));
    assign rdValid = (rdGray_ff != wrGraySync);
    assign rdData = mem[rdBin_ff[AW-1:0]];

    // write side pointer
    always_ff @(posedge wrClk or negedge wrRstN)
    begin
        if (!wrRstN)
        begin
            wrBin_ff <= '0;
            wrGray_ff <= '0;
        end
        else if (wrDo)
        begin
            wrBin_ff <= nxt_wrBin;
            wrGray_ff <= bin2gray(nxt_wrBin);
        end
    end

    // storage, written on the filling clock
    always_ff @(posedge wrClk)
    begin
        if (wrDo)
            mem[wrBin_ff[AW-1:0]] <= wrData;
    end

    // read side pointer
    always_ff @(posedge rdClk or negedge rdRstN)
    begin
        if (!rdRstN)
        begin
            rdBin_ff <= '0;
            rdGray_ff <= '0;
        end
        else if (rdDo)
        begin
            rdBin_ff <= nxt_rdBin;
            rdGray_ff <= bin2gray(nxt_rdBin);
        end
    end

    // pointer crossings
    ssnv_sync2 #(.WIDTH(AW + 1)) rdToWr (
        .clk(wrClk),
        .rstN(wrRstN),
        .d(rdGray_ff),
        .q(rdGraySync)
    );

    ssnv_sync2 #(.WIDTH(AW + 1)) wrToRd (
        .clk(rdClk),
        .rstN(rdRstN),
        .d(wrGray_ff),
        .q(wrGraySync)
    );
endmodule // ssnv_afifo

// ==== hdl/ssnv_top.sv ====
// ssnv_top: serial shadowed memory, 16 words of ram mirrored by a nonvolatile array.
// assumes the host clocks the link only while chip enable is high and keeps data legal
// around the rising edge; the store pin is asynchronous to every clock.
`timescale 1ns/1ps
module ssnv_top #(
    parameter int STORE_CYCLES = ssnv_pkg::STORE_CYCLES,
    parameter int FIFO_DEPTH = ssnv_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic serialClockLine,
    input wire logic chipEnable,
    input wire logic serialInLine,
    input wire logic storeInN,
    output logic dataOut,
    output logic dataOutEn,
    output logic storeBusy,
    output logic writeEnabled
);
    localparam int CMD_W = $bits(ssnv_pkg::ssnv_cmd_t);
    localparam int WB = ssnv_pkg::WORD_BITS;
    localparam int SCW = $clog2(STORE_CYCLES + 1);
    localparam logic [SCW-1:0] STORE_LAST = SCW'(STORE_CYCLES - 1);
    localparam logic [3:0] INSTR_LAST = 4'(ssnv_pkg::INSTR_BITS - 1);
    localparam logic [3:0] WORD_LAST = 4'(ssnv_pkg::WORD_BITS - 1);

    // link side state
    ssnv_pkg::ssnv_lstate_t lState_ff;
    ssnv_pkg::ssnv_lstate_t nxt_lState;
    logic [3:0] bitCnt_ff;
    logic [3:0] nxt_bitCnt;
    logic [WB-1:0] shift_ff;
    logic [WB-1:0] nxt_shift;
    logic [ssnv_pkg::ADDR_BITS-1:0] addr_ff;
    logic dataOut_ff;
    logic nxt_dataOut;
    logic dataOutEn_ff;
    logic cmdReady;
    logic rdValid;
    logic [WB-1:0] rdWord;
    ssnv_pkg::ssnv_cmd_t cmdWr;
    ssnv_pkg::ssnv_kind_t ctlKind;

    // system side state
    ssnv_pkg::ssnv_mstate_t mState_ff;
    ssnv_pkg::ssnv_mstate_t nxt_mState;
    logic [SCW-1:0] storeCnt_ff;
    logic [SCW-1:0] nxt_storeCnt;
    ssnv_pkg::ssnv_mem_t ramMem_ff;
    ssnv_pkg::ssnv_mem_t nvMem_ff;
    logic storeSyncN;
    logic storeLast_ff;
    logic storePend_ff;
    logic wrEn_ff;
    logic storeBusy_ff;
    logic cmdValid;
    logic [CMD_W-1:0] cmdVec;
    logic rdFillReady;
    ssnv_pkg::ssnv_cmd_t cmdRd;

    // chip enable low holds the link logic in reset, so an idle or unselected part is quiet
    wire linkRstN = resetn & chipEnable;

    // instruction decode on the bit that arrives with this edge
    wire [7:0] instrNow = {shift_ff[6:0], serialInLine};
    wire [3:0] addrNow = instrNow[ssnv_pkg::ADDR_MSB:ssnv_pkg::ADDR_LSB];
    wire [2:0] opNow = instrNow[ssnv_pkg::OP_MSB:0];
    wire isWrite = (opNow == ssnv_pkg::OP_WRITE);
    wire isRead = (opNow[2:1] == ssnv_pkg::OP_READ);
    wire ctlOp = (opNow == ssnv_pkg::CTL_STORE) || (opNow == ssnv_pkg::CTL_RECALL) ||
                 (opNow == ssnv_pkg::CTL_WREN) || (opNow == ssnv_pkg::CTL_WRDIS);
    wire isCtl = (addrNow == ssnv_pkg::CTL_ADDR) && ctlOp;
    wire instrLast = (lState_ff == ssnv_pkg::L_INSTR) && (bitCnt_ff == INSTR_LAST);
    wire dataLast = (lState_ff == ssnv_pkg::L_WDATA) && (bitCnt_ff == WORD_LAST);
    wire waitStart = (lState_ff == ssnv_pkg::L_INSTR) && (bitCnt_ff == 4'h0) && !serialInLine;
    wire cmdPush = (instrLast && cmdReady && (isRead || isCtl)) || dataLast;
    wire rdPop = (lState_ff == ssnv_pkg::L_RWAIT);

    // command word toward the system side
    assign ctlKind = (opNow == ssnv_pkg::CTL_STORE) ? ssnv_pkg::K_STORE :
                     (opNow == ssnv_pkg::CTL_RECALL) ? ssnv_pkg::K_RECALL :
                     (opNow == ssnv_pkg::CTL_WREN) ? ssnv_pkg::K_WREN : ssnv_pkg::K_WRDIS;
    assign cmdWr.kind = dataLast ? ssnv_pkg::K_WRITE : (isRead ? ssnv_pkg::K_READ : ctlKind);
    assign cmdWr.addr = dataLast ? addr_ff : addrNow;
    assign cmdWr.data = dataLast ? {shift_ff[WB-2:0], serialInLine} : '0;
    wire [CMD_W-1:0] cmdWrVec = cmdWr;

    // link sequencer: instruction, then write data or read data
    always_comb
    begin
        nxt_lState = lState_ff;
        nxt_bitCnt = bitCnt_ff + 4'h1;
        nxt_shift = {shift_ff[WB-2:0], serialInLine};
        nxt_dataOut = 1'b0;
        case (lState_ff)
            ssnv_pkg::L_INSTR:
            begin
                if (waitStart)
                    nxt_bitCnt = 4'h0;
                else if (instrLast)
                begin
                    nxt_bitCnt = 4'h0;
                    if (!cmdReady)
                        nxt_lState = ssnv_pkg::L_DONE;
                    else if (isWrite)
                        nxt_lState = ssnv_pkg::L_WDATA;
                    else if (isRead)
                        nxt_lState = ssnv_pkg::L_RWAIT;
                    else
                        nxt_lState = ssnv_pkg::L_DONE;
                end
            end
            ssnv_pkg::L_WDATA:
            begin
                if (dataLast)
                    nxt_lState = ssnv_pkg::L_DONE;
            end
            ssnv_pkg::L_RWAIT:
            begin
                nxt_bitCnt = 4'h0;
                nxt_shift = shift_ff;
                if (rdValid)
                begin
                    nxt_lState = ssnv_pkg::L_RDATA;
                    nxt_shift = rdWord;
                    nxt_dataOut = rdWord[WB-1];
                end
            end
            ssnv_pkg::L_RDATA:
            begin
                nxt_shift = {shift_ff[WB-2:0], 1'b0};
                nxt_dataOut = shift_ff[WB-2];
                if (bitCnt_ff == WORD_LAST)
                    nxt_lState = ssnv_pkg::L_DONE;
            end
            ssnv_pkg::L_DONE:
                nxt_bitCnt = bitCnt_ff;
            default:
                nxt_lState = ssnv_pkg::L_DONE;
        endcase
    end

    // link registers, sampled on the rising serial clock
    always_ff @(posedge serialClockLine or negedge linkRstN)
    begin
        if (!linkRstN)
        begin
            lState_ff <= ssnv_pkg::L_INSTR;
            bitCnt_ff <= 4'h0;
            shift_ff <= 16'h0000;
            addr_ff <= 4'h0;
            dataOut_ff <= 1'b0;
            dataOutEn_ff <= 1'b0;
        end
        else
        begin
            lState_ff <= nxt_lState;
            bitCnt_ff <= nxt_bitCnt;
            shift_ff <= nxt_shift;
            addr_ff <= instrLast ? addrNow : addr_ff;
            dataOut_ff <= nxt_dataOut;
            dataOutEn_ff <= (nxt_lState == ssnv_pkg::L_RDATA);
        end
    end

    // store pin crossing and falling edge
    ssnv_sync2 #(.WIDTH(1), .RESET_VAL(ssnv_pkg::STORE_IN_IDLE)) storeSync (
        .clk(mclk),
        .rstN(resetn),
        .d(storeInN),
        .q(storeSyncN)
    );

    // command engine decode
    assign cmdRd = ssnv_pkg::ssnv_cmd_t'(cmdVec);
    wire mIdle = (mState_ff == ssnv_pkg::M_IDLE);
    wire storeFall = storeLast_ff & ~storeSyncN;
    wire isRdCmd = (cmdRd.kind == ssnv_pkg::K_READ);
    wire cmdPop = mIdle && cmdValid && !storePend_ff && (!isRdCmd || rdFillReady);
    wire storeTake = mIdle && storePend_ff;
    wire storeStart = storeTake || (cmdPop && (cmdRd.kind == ssnv_pkg::K_STORE) && wrEn_ff);
    wire recallNow = (mState_ff == ssnv_pkg::M_BOOT) ||
                     (cmdPop && (cmdRd.kind == ssnv_pkg::K_RECALL));
    wire ramWrite = cmdPop && (cmdRd.kind == ssnv_pkg::K_WRITE) && wrEn_ff;
    wire rdPush = cmdPop && isRdCmd;
    wire nxt_storePend = storeFall | (storePend_ff & ~storeTake);
    wire nxt_wrEn = (cmdPop && (cmdRd.kind == ssnv_pkg::K_WREN)) ? 1'b1 :
                    (cmdPop && (cmdRd.kind == ssnv_pkg::K_WRDIS)) ? 1'b0 : wrEn_ff;
    wire [WB-1:0] ramRdWord = ramMem_ff[cmdRd.addr];

    // engine sequencer: boot recall, idle, timed store
    always_comb
    begin
        nxt_mState = mState_ff;
        nxt_storeCnt = storeCnt_ff;
        case (mState_ff)
            ssnv_pkg::M_BOOT:
                nxt_mState = ssnv_pkg::M_IDLE;
            ssnv_pkg::M_IDLE:
            begin
                if (storeStart)
                begin
                    nxt_mState = ssnv_pkg::M_STORE;
                    nxt_storeCnt = STORE_LAST;
                end
            end
            ssnv_pkg::M_STORE:
            begin
                if (storeCnt_ff == '0)
                    nxt_mState = ssnv_pkg::M_IDLE;
                else
                    nxt_storeCnt = storeCnt_ff - SCW'(1);
            end
            default:
                nxt_mState = ssnv_pkg::M_IDLE;
        endcase
    end

    // engine control registers
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            mState_ff <= ssnv_pkg::M_BOOT;
            storeCnt_ff <= '0;
            storeLast_ff <= ssnv_pkg::STORE_IN_IDLE;
            storePend_ff <= 1'b0;
            wrEn_ff <= ssnv_pkg::WREN_RESET;
            storeBusy_ff <= 1'b0;
        end
        else
        begin
            mState_ff <= nxt_mState;
            storeCnt_ff <= nxt_storeCnt;
            storeLast_ff <= storeSyncN;
            storePend_ff <= nxt_storePend;
            wrEn_ff <= nxt_wrEn;
            storeBusy_ff <= (nxt_mState == ssnv_pkg::M_STORE);
        end
    end

    // shadow ram and nonvolatile array, whole-array transfers
    always_ff @(posedge mclk)
    begin
        if (recallNow)
            ramMem_ff <= nvMem_ff;
        else if (ramWrite)
            ramMem_ff[cmdRd.addr] <= cmdRd.data;
        if (storeStart)
            nvMem_ff <= ramMem_ff;
    end

    // command and read-data crossings
    ssnv_afifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) cmdFifo (
        .wrClk(serialClockLine),
        .wrRstN(resetn),
        .wrValid(cmdPush),
        .wrReady(cmdReady),
        .wrData(cmdWrVec),
        .rdClk(mclk),
        .rdRstN(resetn),
        .rdValid(cmdValid),
        .rdReady(cmdPop),
        .rdData(cmdVec)
    );

    ssnv_afifo #(.WIDTH(WB), .DEPTH(FIFO_DEPTH)) rdFifo (
        .wrClk(mclk),
        .wrRstN(resetn),
        .wrValid(rdPush),
        .wrReady(rdFillReady),
        .wrData(ramRdWord),
        .rdClk(serialClockLine),
        .rdRstN(resetn),
        .rdValid(rdValid),
        .rdReady(rdPop),
        .rdData(rdWord)
    );

    // outputs
    assign dataOut = dataOut_ff;
    assign dataOutEn = dataOutEn_ff;
    assign storeBusy = storeBusy_ff;
    assign writeEnabled = wrEn_ff;

    // checks on the system clock
    property p_store_copy;
        @(posedge mclk) disable iff (!resetn) storeStart |=> (nvMem_ff == $past(ramMem_ff));
    endproperty
    a_store_copy: assert property (p_store_copy)
        else $error("store did not copy the ram");

    property p_store_arm;
        @(posedge mclk) disable iff (!resetn)
            storeStart |=> storeBusy_ff && (storeCnt_ff == STORE_LAST);
    endproperty
    a_store_arm: assert property (p_store_arm)
        else $error("store timer not armed");

    property p_store_end;
        @(posedge mclk) disable iff (!resetn)
            (storeBusy_ff && (storeCnt_ff == '0)) |=> !storeBusy_ff;
    endproperty
    a_store_end: assert property (p_store_end)
        else $error("store ran past its interval");

    property p_recall_copy;
        @(posedge mclk) disable iff (!resetn) recallNow |=> (ramMem_ff === $past(nvMem_ff));
    endproperty
    a_recall_copy: assert property (p_recall_copy)
        else $error("recall did not reload the ram");

    property p_nv_only_store;
        @(posedge mclk) disable iff (!resetn) !$stable(nvMem_ff) |-> $past(storeStart);
    endproperty
    a_nv_only_store: assert property (p_nv_only_store)
        else $error("array changed without a store");

    property p_ram_write;
        @(posedge mclk) disable iff (!resetn)
            ramWrite |=> (ramMem_ff[$past(cmdRd.addr)] == $past(cmdRd.data));
    endproperty
    a_ram_write: assert property (p_ram_write)
        else $error("ram word not written");

    property p_quiet_unselected;
        @(posedge mclk) disable iff (!resetn) !chipEnable |=> !dataOutEn_ff;
    endproperty
    a_quiet_unselected: assert property (p_quiet_unselected)
        else $error("data out driven while unselected");

    // checks on the link clock
    property p_ctl_addr;
        @(posedge serialClockLine) disable iff (!linkRstN)
            (instrLast && !isWrite && !isRead) |-> (cmdPush == (isCtl && cmdReady));
    endproperty
    a_ctl_addr: assert property (p_ctl_addr)
        else $error("control decode wrong");

    property p_write_len;
        @(posedge serialClockLine) disable iff (!linkRstN)
            (cmdPush && (cmdWr.kind == ssnv_pkg::K_WRITE)) |-> $past(instrLast, 16);
    endproperty
    a_write_len: assert property (p_write_len)
        else $error("write data not sixteen bits");

    property p_msb_first;
        @(posedge serialClockLine) disable iff (!linkRstN)
            instrLast |-> instrNow[ssnv_pkg::INSTR_START_POS] &&
                (instrNow[ssnv_pkg::INSTR_START_POS] == $past(serialInLine, 7));
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("instruction not shifted msb first");
endmodule // ssnv_top

// ==== testbench/ssnv_host.sv ====
// ssnv_host: host microcontroller and power-fail circuit facing the serial shadow memory.
// assumes the bench calls its tasks one at a time; link clock runs only inside frames.
`timescale 1ns/1ps
module ssnv_host (
    input wire logic mclk,
    input wire logic dataOut,
    input wire logic dataOutEn,
    output logic serialClockLine,
    output logic chipEnable,
    output logic serialInLine,
    output logic storeInN
);
    logic [15:0] rdWord;
    logic rdEnd;

    // idle levels: enable, data and clock low, store pin high
    initial
    begin
        serialClockLine = 1'h0;
        chipEnable = 1'h0;
        serialInLine = 1'h0;
        storeInN = 1'h1;
        rdWord = 16'h0000;
        rdEnd = 1'h0;
    end

    // one 15 ns link period: data set while clock low, then a rising edge
    task automatic linkBit(input logic b);
        serialInLine = b;
        #7.5 serialClockLine = 1'h1;
        #7.5 serialClockLine = 1'h0;
    endtask

    // instruction then optional data word, msb first; sel low leaves device deselected
    task automatic frame(input logic sel, input logic [7:0] ins, input logic wr,
        input logic [15:0] data);
        @(negedge mclk);
        chipEnable = sel;
        for (int i = 7; i >= 0; i--)
            linkBit(ins[i]);
        if (wr)
        begin
            for (int i = 15; i >= 0; i--)
                linkBit(data[i]);
        end
        serialInLine = 1'h0;
        #7.5 chipEnable = 1'h0;
        repeat (8) @(negedge mclk);
    endtask

    // read: instruction, wait for the crossing and the first data edge, then 15 data edges and one closing edge
    task automatic readWord(input logic [3:0] a);
        int n;
        logic [7:0] ins;
        ins = {1'h1, a, 3'h6};
        n = 0;
        @(negedge mclk);
        chipEnable = 1'h1;
        for (int i = 7; i >= 0; i--)
            linkBit(ins[i]);
        #120;
        while (dataOutEn !== 1'h1 && n < 40)
        begin
            linkBit(1'h0);
            n++;
        end
        rdWord[15] = dataOut;
        for (int i = 14; i >= 0; i--)
        begin
            linkBit(1'h0);
            rdWord[i] = dataOut;
        end
        linkBit(1'h0);
        rdEnd = (dataOutEn === 1'h0);
        #7.5 chipEnable = 1'h0;
        repeat (8) @(negedge mclk);
    endtask

    // power-fail circuit drives the store pin
    task automatic setStore(input logic lvl);
        @(negedge mclk);
        storeInN = lvl;
    endtask
endmodule // ssnv_host

// ==== testbench/ssnv_top_test.sv ====
// ssnv_top_test: self-checking bench of the serial shadow memory with a host model.
// assumes the store time is shortened to 20 mclk cycles through the parameter.
`timescale 1ns/1ps
module ssnv_top_test;
    localparam int STORE_N = 20;
    localparam int LIMIT = 50000;
    logic mclk;
    logic resetn;
    logic serialClockLine;
    logic chipEnable;
    logic serialInLine;
    logic storeInN;
    logic dataOut;
    logic dataOutEn;
    logic storeBusy;
    logic writeEnabled;
    int miscompares;
    int num_checks;
    int cycles;

    ssnv_top #(.STORE_CYCLES(STORE_N)) i_dut (
        .mclk(mclk), .resetn(resetn), .serialClockLine(serialClockLine),
        .chipEnable(chipEnable), .serialInLine(serialInLine), .storeInN(storeInN),
        .dataOut(dataOut), .dataOutEn(dataOutEn), .storeBusy(storeBusy),
        .writeEnabled(writeEnabled)
    );

    ssnv_host i_host (
        .mclk(mclk), .dataOut(dataOut), .dataOutEn(dataOutEn),
        .serialClockLine(serialClockLine), .chipEnable(chipEnable),
        .serialInLine(serialInLine), .storeInN(storeInN)
    );

    // 125 MHz system clock
    always #4 mclk = ~mclk;

    // hang guard
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: timeout", $time);
            results();
        end
    end

    function automatic logic [15:0] pat(input logic [3:0] a);
        return {a, ~a, a ^ 4'h5, 4'hC};
    endfunction

    task automatic chkBit(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %b", $time, what, got);
        end
    endtask

    task automatic chkWord(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic ctl(input logic [2:0] op);
        i_host.frame(1'h1, {1'h1, 4'hF, op}, 1'h0, 16'h0000);
    endtask

    task automatic wrWord(input logic [3:0] a, input logic [15:0] d);
        i_host.frame(1'h1, {1'h1, a, 3'h3}, 1'h1, d);
    endtask

    task automatic readChk(input logic [3:0] a, input logic [15:0] exp);
        i_host.readWord(a);
        chkWord(i_host.rdWord, exp, "read word");
        chkBit(i_host.rdEnd, 1'h1, "read end");
    endtask

    // measure a store: rise within maxWait cycles, then busy exactly STORE_N cycles
    task automatic chkStore(input int maxWait);
        int n;
        n = 0;
        while (storeBusy !== 1'h1 && n < maxWait)
        begin
            @(negedge mclk);
            n++;
        end
        chkBit(storeBusy, 1'h1, "store start");
        n = 0;
        while (storeBusy === 1'h1 && n < 100)
        begin
            @(negedge mclk);
            n++;
        end
        chkWord(16'(n), 16'(STORE_N), "store length");
    endtask

    task automatic doReset();
        @(negedge mclk);
        resetn = 1'h0;
        repeat (4) @(negedge mclk);
        resetn = 1'h1;
        repeat (4) @(negedge mclk);
    endtask

    task automatic testBoot();
        chkBit(storeBusy, 1'h0, "busy after reset");
        chkBit(writeEnabled, 1'h0, "latch after reset");
    endtask

    task automatic testWriteRead();
        ctl(3'h4);
        chkBit(writeEnabled, 1'h1, "write enable");
        for (int i = 0; i < 16; i++)
            wrWord(4'(i), pat(4'(i)));
        for (int i = 15; i >= 0; i--)
            readChk(4'(i), pat(4'(i)));
    endtask

    task automatic testPinStore();
        i_host.setStore(1'h0);
        chkStore(10);
        i_host.setStore(1'h1);
    endtask

    task automatic testRecall();
        wrWord(4'h3, 16'h1234);
        readChk(4'h3, 16'h1234);
        ctl(3'h5);
        readChk(4'h3, pat(4'h3));
    endtask

    task automatic testDeselect();
        i_host.frame(1'h0, {1'h1, 4'h6, 3'h3}, 1'h1, 16'hBEEF);
        chkBit(dataOutEn, 1'h0, "deselected drive");
        readChk(4'h6, pat(4'h6));
    endtask

    task automatic testWriteDisable();
        ctl(3'h0);
        chkBit(writeEnabled, 1'h0, "write disable");
        wrWord(4'h5, 16'hDEAD);
        readChk(4'h5, pat(4'h5));
    endtask

    task automatic testStoreCmd();
        ctl(3'h4);
        // watch the store while the frame still runs, so its whole interval is counted
        fork
            i_host.frame(1'h1, {1'h1, 4'hF, 3'h1}, 1'h0, 16'h0000);
            chkStore(40);
        join
    endtask

    task automatic testPowerOn();
        doReset();
        chkBit(writeEnabled, 1'h0, "latch after second reset");
        readChk(4'h9, pat(4'h9));
    endtask

    task automatic results();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // main sequence
    initial
    begin
        mclk = 1'h0;
        resetn = 1'h0;
        miscompares = 0;
        num_checks = 0;
        cycles = 0;
        doReset();
        testBoot();
        testWriteRead();
        testPinStore();
        testRecall();
        testDeselect();
        testWriteDisable();
        testStoreCmd();
        testPowerOn();
        results();
    end
endmodule // ssnv_top_test
